// ---- src/bpu_pkg.sv ----
// shared constants and types for the basic pulse unit core
package bpu_pkg;
  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int DIV_W = 12;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
  localparam logic [1:0] TYPE_UP = 2'h0;
  localparam logic [1:0] TYPE_DOWN = 2'h1;
  localparam logic [1:0] TYPE_UPDOWN = 2'h2;
  // waveform actions, two bits per event
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // action field base positions within the control words, each channel at 2*g above
  localparam int ZERO_ACT_POS = 0;
  localparam int PER_ACT_POS = 2 * NUM_CH;
  localparam int COMPARE_RISING_MATCH_ACT_POS = 0;
  localparam int COMPARE_FALLING_MATCH_ACT_POS = 2 * NUM_CH;
  localparam int WG_W = 4 * NUM_CH;
endpackage

// ---- src/bpu_prescaler.sv ----
// clock prescaler producing one tick per divide+1 kernel clocks
`timescale 1ns/100ps
module bpu_prescaler #(
  parameter int DW = 12
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // divide setting and tick
  input wire logic [DW-1:0] clock_divide_value_i,
  output logic tick_o
);
  import bpu_pkg::*;
  logic [DW-1:0] psc_r;
  logic [DW-1:0] psc_nxt;
  wire psc_zero = (psc_r == '0);

  // reload at end of each down-count so a new divide applies from the next down-count
  assign psc_nxt = psc_zero ? clock_divide_value_i : psc_r - 1'b1;
  assign tick_o = psc_zero;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      psc_r <= '0;
    end else begin
      psc_r <= psc_nxt;
    end
  end
endmodule

// ---- src/bpu_channel.sv ----
// one channel: compare shadow, match events and waveform generator
`timescale 1ns/100ps
module bpu_channel #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // shared counter state
  input wire logic tick_i,
  input wire logic [CW-1:0] count_i,
  input wire logic dir_up_i,
  input wire logic [1:0] count_type_i,
  input wire logic zero_ev_i,
  input wire logic per_ev_i,
  input wire logic period_end_i,
  // configuration
  input wire logic [CW-1:0] compare_value_i,
  input wire logic instant_load_i,
  input wire logic midpoint_load_i,
  input wire logic [1:0] act_zero_i,
  input wire logic [1:0] act_per_i,
  input wire logic [1:0] act_compare_rising_match_i,
  input wire logic [1:0] act_compare_falling_match_i,
  // results
  output logic [CW-1:0] active_compare_o,
  output logic cmp_up_o,
  output logic cmp_dn_o,
  output logic wave_o
);
  import bpu_pkg::*;
  logic [CW-1:0] cmp_r;
  logic wave_r;
  logic [1:0] act;
  wire eq = tick_i && (count_i == cmp_r);
  wire cu = eq && dir_up_i;
  wire cd = eq && !dir_up_i;
  wire ud = (count_type_i == TYPE_UPDOWN);
  // immediate loading overrides both other modes
  wire mid_ld = midpoint_load_i && ud && per_ev_i;
  wire ld = instant_load_i || mid_ld ||
            (!(midpoint_load_i && ud) && period_end_i);

  // event priority per count type, highest checked first
  always_comb begin
    act = ACT_NONE;
    if (count_type_i == TYPE_DOWN) begin
      if (zero_ev_i) act = act_zero_i;
      else if (cd) act = act_compare_falling_match_i;
      else if (per_ev_i) act = act_per_i;
    end else if (ud) begin
      if (cu) act = act_compare_rising_match_i;
      else if (cd) act = act_compare_falling_match_i;
      else if (zero_ev_i) act = act_zero_i;
      else if (per_ev_i) act = act_per_i;
    end else begin
      if (per_ev_i) act = act_per_i;
      else if (cu) act = act_compare_rising_match_i;
      else if (zero_ev_i) act = act_zero_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmp_r <= CNT_RST;
      wave_r <= 1'b0;
    end else begin
      if (ld) cmp_r <= compare_value_i;
      case (act)
        ACT_LOW: wave_r <= 1'b0;
        ACT_HIGH: wave_r <= 1'b1;
        ACT_TOGGLE: wave_r <= ~wave_r;
        default: wave_r <= wave_r;
      endcase
    end
  end

  assign active_compare_o = cmp_r;
  assign cmp_up_o = cu;
  assign cmp_dn_o = cd;
  assign wave_o = wave_r;
endmodule

// ---- src/bpu_core.sv ----
// six-channel pulse counter, compare and waveform core
`timescale 1ns/100ps
module bpu_core #(
  parameter int NCH = bpu_pkg::NUM_CH,
  parameter int CW = bpu_pkg::CNT_W,
  parameter int DW = bpu_pkg::DIV_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // counter configuration
  input wire logic [DW-1:0] clock_divide_value_i,
  input wire logic [1:0] count_type_field_i,
  input wire logic count_clear_set_i,
  input wire logic [CW-1:0] period_value_i,
  // per-channel configuration and the max flag clear
  input wire logic [NCH*CW-1:0] compare_value_i,
  input wire logic [NCH-1:0] instant_load_enable_i,
  input wire logic [NCH-1:0] midpoint_load_enable_i,
  input wire logic [4*NCH-1:0] waveform_action_ctl_a_i,
  input wire logic [4*NCH-1:0] waveform_action_ctl_b_i,
  input wire logic count_max_clear_i,
  // status
  output logic [CW:0] count_value_o,
  output logic count_clear_bit_o,
  output logic count_max_flag_o,
  output logic [CW-1:0] active_period_o,
  output logic [NCH*CW-1:0] active_compare_o,
  // events and waveforms
  output logic zero_event_o,
  output logic period_event_o,
  output logic [NCH-1:0] compare_rising_match_o,
  output logic [NCH-1:0] compare_falling_match_o,
  output logic [NCH-1:0] wave_o
);
  import bpu_pkg::*;

  logic tick;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic dir_r;
  logic dir_nxt;
  logic [CW-1:0] per_r;
  logic clr_r;
  logic max_r;
  logic zero_ev_r;
  logic per_ev_r;
  logic [NCH-1:0] cu_r;
  logic [NCH-1:0] cd_r;
  logic [NCH*CW-1:0] acmp;
  logic [NCH-1:0] cu;
  logic [NCH-1:0] cd;
  logic [NCH-1:0] wv;

  // one prescaler feeds the single shared counter
  bpu_prescaler #(.DW(DW)) u_psc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clock_divide_value_i(clock_divide_value_i),
    .tick_o(tick)
  );

  // decode of the count type and present position
  wire t_down = (count_type_field_i == TYPE_DOWN);
  wire t_ud = (count_type_field_i == TYPE_UPDOWN);
  wire at_zero = (cnt_r == CNT_RST);
  wire at_per = (cnt_r == per_r);
  wire at_max = (cnt_r == CNT_MAX);
  // events are valid for the last clock of each count step
  wire zero_ev = tick && at_zero;
  wire per_ev = tick && at_per;
  // end of one full period, used for period loading
  wire per_end = tick && (t_down ? at_zero :
                 t_ud ? (at_zero && !dir_r) : at_per);
  // any instant channel lets period load after the current count step;
  // in up count, a period below the count then runs the counter on to max
  wire any_inst = |instant_load_enable_i;
  wire per_ld = per_end || (any_inst && tick);
  // up-count-type overrun past a shortened period
  wire overrun = !t_down && !t_ud && (cnt_r > per_r);

  // next count; up count wraps at max, giving the overrun path
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (tick) begin
      if (clr_r) begin
        cnt_nxt = CNT_RST;
      end else if (t_down) begin
        dir_nxt = 1'b0;
        cnt_nxt = at_zero ? per_r : cnt_r - 1'b1;
      end else if (t_ud) begin
        if (dir_r && (at_per || cnt_r > per_r)) begin
          dir_nxt = 1'b0;
          cnt_nxt = at_zero ? CNT_RST : cnt_r - 1'b1;
        end else if (!dir_r && at_zero) begin
          dir_nxt = 1'b1;
          cnt_nxt = (per_r == CNT_RST) ? CNT_RST : cnt_r + 1'b1;
        end else begin
          cnt_nxt = dir_r ? cnt_r + 1'b1 : cnt_r - 1'b1;
        end
      end else begin
        dir_nxt = 1'b1;
        // at period or at max wrap to zero; otherwise step up
        cnt_nxt = (at_per || at_max) ? CNT_RST : cnt_r + 1'b1;
      end
    end
  end

  // counter, direction and period shadow
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_r <= CNT_RST;
      dir_r <= 1'b1;
      per_r <= CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      if (per_ld) per_r <= period_value_i;
    end
  end

  // clear request held until the next prescaler zero, then self-clears
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clr_r <= 1'b0;
    end else if (count_clear_set_i) begin
      clr_r <= 1'b1;
    end else if (tick) begin
      clr_r <= 1'b0;
    end
  end

  // sticky max flag; a new max hit wins over software clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      max_r <= 1'b0;
    end else if (tick && at_max && overrun) begin
      max_r <= 1'b1;
    end else if (count_max_clear_i) begin
      max_r <= 1'b0;
    end
  end

  // one comparator and generator per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      bpu_channel #(.CW(CW)) u_ch (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .count_i(cnt_r),
        .dir_up_i(dir_r),
        .count_type_i(count_type_field_i),
        .zero_ev_i(zero_ev),
        .per_ev_i(per_ev),
        .period_end_i(per_end),
        .compare_value_i(compare_value_i[g*CW +: CW]),
        .instant_load_i(instant_load_enable_i[g]),
        .midpoint_load_i(midpoint_load_enable_i[g]),
        .act_zero_i(waveform_action_ctl_a_i[ZERO_ACT_POS+2*g +: 2]),
        .act_per_i(waveform_action_ctl_a_i[PER_ACT_POS+2*g +: 2]),
        .act_compare_rising_match_i(waveform_action_ctl_b_i[COMPARE_RISING_MATCH_ACT_POS+2*g +: 2]),
        .act_compare_falling_match_i(waveform_action_ctl_b_i[COMPARE_FALLING_MATCH_ACT_POS+2*g +: 2]),
        .active_compare_o(acmp[g*CW +: CW]),
        .cmp_up_o(cu[g]),
        .cmp_dn_o(cd[g]),
        .wave_o(wv[g])
      );
    end
  endgenerate

  // registered event outputs, one clock late but aligned together
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      zero_ev_r <= 1'b0;
      per_ev_r <= 1'b0;
      cu_r <= '0;
      cd_r <= '0;
    end else begin
      zero_ev_r <= zero_ev;
      per_ev_r <= per_ev;
      cu_r <= cu;
      cd_r <= cd;
    end
  end

  assign count_value_o = {dir_r, cnt_r};
  assign count_clear_bit_o = clr_r;
  assign count_max_flag_o = max_r;
  assign active_period_o = per_r;
  assign active_compare_o = acmp;
  assign zero_event_o = zero_ev_r;
  assign period_event_o = per_ev_r;
  assign compare_rising_match_o = cu_r;
  assign compare_falling_match_o = cd_r;
  assign wave_o = wv;

  // prescale spacing: counter only moves on a tick
  property p_step_on_tick;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!tick) |=> $stable(cnt_r);
  endproperty
  a_step_on_tick: assert property (p_step_on_tick)
    else $error("counter moved without prescale tick");

  property p_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    (tick && clr_r && !count_clear_set_i) |=> (cnt_r == '0) && !clr_r;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero counter");

  property p_up_wrap;
    @(posedge sys_clk_i) disable iff (rst_i)
    (tick && !clr_r && count_type_field_i == TYPE_UP && at_per)
      |=> (cnt_r == '0);
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("up count did not wrap at period");

  property p_down_reload;
    @(posedge sys_clk_i) disable iff (rst_i)
    (tick && !clr_r && t_down && at_zero) |=> (cnt_r == $past(per_r));
  endproperty
  a_down_reload: assert property (p_down_reload)
    else $error("down count did not reload period");

  property p_dir_down;
    @(posedge sys_clk_i) disable iff (rst_i)
    (t_down && tick && !clr_r) |=> !count_value_o[CW];
  endproperty
  a_dir_down: assert property (p_dir_down)
    else $error("direction flag high in down type");

  property p_zero_ev;
    @(posedge sys_clk_i) disable iff (rst_i)
    (tick && at_zero) |=> zero_event_o;
  endproperty
  a_zero_ev: assert property (p_zero_ev)
    else $error("zero event missing");

  property p_max_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    (tick && at_max && overrun) |=> count_max_flag_o;
  endproperty
  a_max_flag: assert property (p_max_flag)
    else $error("max flag not set");

  property p_period_load;
    @(posedge sys_clk_i) disable iff (rst_i)
    (per_end) |=> (active_period_o == $past(period_value_i));
  endproperty
  a_period_load: assert property (p_period_load)
    else $error("period shadow not loaded at period end");
endmodule

// ---- test/tb.sv ----
// self-checking bench for the pulse counter core
`timescale 1ns/100ps
module tb;
  import bpu_pkg::*;
  // stimulus, all driven on the falling edge
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] div = 12'h000;
  logic [1:0] typ = 2'h0;
  logic clr = 1'b0;
  logic mclr = 1'b0;
  logic [15:0] per = 16'h0008;
  logic [95:0] cmp = 96'h0;
  logic [5:0] imm = 6'h00;
  logic [5:0] mid = 6'h00;
  logic [23:0] wa = 24'h0;
  logic [23:0] wb = 24'h0;
  // observed outputs
  logic [16:0] cnt;
  logic cbit, mflag, zev, pev;
  logic [15:0] aper;
  logic [95:0] acmp;
  logic [5:0] cru, crd, wave;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int d, p;
  logic [5:0] w;

  bpu_core dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .clock_divide_value_i(div), .count_type_field_i(typ),
    .count_clear_set_i(clr), .period_value_i(per),
    .compare_value_i(cmp), .instant_load_enable_i(imm),
    .midpoint_load_enable_i(mid), .waveform_action_ctl_a_i(wa),
    .waveform_action_ctl_b_i(wb), .count_max_clear_i(mclr),
    .count_value_o(cnt), .count_clear_bit_o(cbit),
    .count_max_flag_o(mflag), .active_period_o(aper),
    .active_compare_o(acmp), .zero_event_o(zev),
    .period_event_o(pev), .compare_rising_match_o(cru),
    .compare_falling_match_o(crd), .wave_o(wave));

  always #5 sys_clk_i = ~sys_clk_i;

  // hang guard, well above the longest expected run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  // zero action / compare-up in low half, period / compare-down in high
  function automatic logic [23:0] acts(logic [1:0] l, logic [1:0] h);
    return {{6{h}}, {6{l}}};
  endfunction

  // waits for an event pulse, returns on that cycle's falling edge
  task automatic wev(input logic pe);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while ((pe ? pev : zev) !== 1'b1 && k < 20000);
    if (k >= 20000) chk(1'b0, "event wait");
  endtask

  // period length between two period or center events
  task automatic gap(input logic [1:0] t, input int dv, input int pv);
    int g, e;
    typ = t;
    div = dv[11:0];
    per = pv[15:0];
    wa = 24'h0;
    wb = 24'h0;
    repeat (3) wev(1'b1);
    g = 0;
    do begin
      @(negedge sys_clk_i);
      g++;
    end while (pev !== 1'b1 && g < 20000);
    e = (t == TYPE_UPDOWN) ? 2 * pv * (dv + 1) : (pv + 1) * (dv + 1);
    chk(g == e, "period length");
    chk(aper === pv[15:0], "period shadow");
    if (t != TYPE_UPDOWN) chk(cnt[16] === (t == TYPE_UP), "dir");
  endtask

  // one rising and one falling match per up-down period
  task automatic cmpcnt(input int pv, input int c);
    int nu, nd, k;
    typ = TYPE_UPDOWN;
    per = pv[15:0];
    cmp = {6{c[15:0]}};
    repeat (3) wev(1'b0);
    nu = 0;
    nd = 0;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
      if (cru === 6'h3F) nu++;
      if (crd === 6'h3F) nd++;
    end while (zev !== 1'b1 && k < 20000);
    chk(nu == 1 && nd == 1, "compare matches");
  endtask

  // coinciding events; only the colliding actions are set, except that up-down sets both compare actions
  task automatic prio(input logic [1:0] t, input logic [15:0] c,
      input logic [23:0] a, input logic [23:0] b, input logic e);
    typ = t;
    div = 12'h000;
    per = 16'h0006;
    cmp = {6{c}};
    wa = a;
    wb = b;
    repeat (3) wev(1'b1);
    repeat (2) @(negedge sys_clk_i);
    chk(wave === {6{e}}, "event priority");
  endtask

  // compare shadow timing, period-end versus midpoint loading
  task automatic loadchk(input logic [5:0] m);
    logic [95:0] c1;
    c1 = {$urandom, $urandom, $urandom};
    typ = TYPE_UPDOWN;
    div = 12'h000;
    per = 16'h0028;
    mid = m;
    cmp = c1;
    repeat (3) wev(1'b0);
    cmp = ~c1;
    @(negedge sys_clk_i);
    chk(acmp === c1, "compare held");
    wev(1'b1);
    @(negedge sys_clk_i);
    chk(acmp === ((m != 6'h00) ? ~c1 : c1), "center load");
    wev(1'b0);
    @(negedge sys_clk_i);
    chk(acmp === ~c1, "period-end load");
  endtask

  initial begin
    int k;
    void'($urandom(32'hA2CD0BD2));
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(cnt === 17'h10000 && aper === 16'h0000 && acmp === 96'h0
      && wave === 6'h00 && mflag === 1'b0, "reset state");
    rst_i = 1'b0;
    // random divide and period over every count type
    for (int i = 0; i < 6; i++) begin
      d = $urandom_range(3);
      p = $urandom_range(20, 3);
      gap(i % 3, d, p);
    end
    p = $urandom_range(20, 4);
    cmpcnt(p, $urandom_range(p - 1, 1));
    prio(TYPE_UP, 16'h0006, acts(ACT_NONE, ACT_HIGH),
      acts(ACT_LOW, ACT_NONE), 1'b1);
    prio(TYPE_UP, 16'h0006, acts(ACT_NONE, ACT_LOW),
      acts(ACT_HIGH, ACT_NONE), 1'b0);
    prio(TYPE_UP, 16'h0000, acts(ACT_HIGH, ACT_NONE),
      acts(ACT_LOW, ACT_NONE), 1'b0);
    prio(TYPE_DOWN, 16'h0000, acts(ACT_HIGH, ACT_NONE),
      acts(ACT_NONE, ACT_LOW), 1'b1);
    prio(TYPE_DOWN, 16'h0006, acts(ACT_NONE, ACT_HIGH),
      acts(ACT_NONE, ACT_LOW), 1'b0);
    prio(TYPE_UPDOWN, 16'h0000, acts(ACT_HIGH, ACT_NONE),
      acts(ACT_LOW, ACT_LOW), 1'b0);
    prio(TYPE_UPDOWN, 16'h0006, acts(ACT_NONE, ACT_LOW),
      acts(ACT_HIGH, ACT_HIGH), 1'b1);
    // toggle on the period event flips every period; three flips from high
    prio(TYPE_UP, 16'h0003, acts(ACT_NONE, ACT_TOGGLE), 24'h0, 1'b0);
    wev(1'b1);
    w = wave;
    wev(1'b1);
    chk(wave === ~w, "toggle");
    loadchk(6'h00);
    loadchk(6'h3F);
    // instant load wins even with midpoint load set
    per = 16'h03E8;
    imm = 6'h3F;
    repeat (3) begin
      cmp = {$urandom, $urandom, $urandom};
      repeat (2) @(negedge sys_clk_i);
      chk(acmp === cmp, "instant compare");
    end
    // shorter period below the count runs on to the top and wraps
    typ = TYPE_UP;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (cnt[15:0] < 16'h0064 && k < 5000);
    per = 16'h0032;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (mflag !== 1'b1 && k < 70000);
    chk(mflag === 1'b1, "max flag");
    repeat (3) @(negedge sys_clk_i);
    chk(cnt[15:0] < 16'h0006, "wrap after max");
    mclr = 1'b1;
    @(negedge sys_clk_i);
    mclr = 1'b0;
    @(negedge sys_clk_i);
    chk(mflag === 1'b0, "max flag clear");
    // clear request lands on the next prescale tick
    imm = 6'h00;
    div = 12'h007;
    per = 16'h03E8;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (cnt[15:0] < 16'h0014 && k < 5000);
    clr = 1'b1;
    @(negedge sys_clk_i);
    clr = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    chk(cnt[15:0] < 16'h0002 && cbit === 1'b0, "counter clear");
    test_done();
  end
endmodule
